// ===== sds_defines.vh
/*
 * Timing counts, field codes and limits for the smoke detector sequencer.
 * Assumes a 200 MHz ref_clk and a 1 ms internal tick.
 */
`ifndef SDS_DEFINES_VH
`define SDS_DEFINES_VH
`define SDS_CLK_PERIOD_NS 5
`define SDS_TICK_NS       1000000
`define SDS_INFRARED_EMITTER_DRIVE_STEP_US  100
`define SDS_SAMPLE_S      10
`define SDS_WINDOW_MS     10
`define SDS_INFRARED_EMITTER_DRIVE_START_MS 2
`define SDS_FAST_MS       250
`define SDS_SUPV_S        43
`define SDS_OFFSET_S      20
`define SDS_CHIRP_MS      10
`define SDS_TRIPLE_GAP_MS 330
`define SDS_FLASH_MS      10
`define SDS_ALARM_RATE_MS 500
`define SDS_LBHOLD_MS     500
`define SDS_LBMUTE_H      8
`define SDS_HUSH_MIN      9
`define SDS_IODUMP_MS     1300
`define SDS_IOFILT_MS     336
`define SDS_MEM_GAP_MS    1300
`define SDS_MEM_SHOW_H    24
`define SDS_EOL_DAYS      14
`define SDS_EOL_YEARS     10
`define SDS_DETECT_COUNT  2'h3
`define SDS_GAIN_NORMAL   2'h0
`define SDS_GAIN_HUSH     2'h1
`define SDS_GAIN_HIGH     2'h2
`define SDS_LIM_NORMAL    2'h0
`define SDS_LIM_HYST      2'h1
`define SDS_LIM_HUSH      2'h2
`define SDS_LIM_CHAMBER   2'h3
`endif

// ===== sds_burst.v
/*
 * Burst generator: count pulses of on_ms, one every gap_ms, on 1 ms ticks.
 * Assumes start, count and timing are steady logic on ref_clk.
 */
`timescale 1ns/100ps
module sds_burst (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire        tick,
  input  wire        start,
  input  wire [1:0]  count,
  input  wire [11:0] on_ms,
  input  wire [11:0] gap_ms,
  output reg         busy_reg,
  output reg         out_reg
);
  reg [1:0]  left_reg;
  reg [11:0] t_reg;

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      busy_reg <= 1'b0;
      left_reg <= 2'h0;
      t_reg    <= 12'h000;
      out_reg  <= 1'b0;
    end else begin
      out_reg <= busy_reg && (t_reg < on_ms);
      if (!busy_reg && start && count != 2'h0) begin
        busy_reg <= 1'b1;
        left_reg <= count;
        t_reg    <= 12'h000;
      end else if (busy_reg && tick) begin
        if (t_reg == gap_ms - 12'h001) begin
          t_reg    <= 12'h000;
          left_reg <= left_reg - 2'h1;
          if (left_reg == 2'h1)
            busy_reg <= 1'b0;
        end else begin
          t_reg <= t_reg + 12'h001;
        end
      end
    end
  end
endmodule

// ===== sds_io_filter.v
/*
 * Interconnect input: two-stage synchroniser then an up/down filter.
 * Assumes io_pin is asynchronous; tick is a 1 ms pulse on ref_clk.
 */
`timescale 1ns/100ps
`include "sds_defines.vh"
module sds_io_filter #(
  parameter [8:0] FILT_MS = `SDS_IOFILT_MS
) (
  input  wire ref_clk,
  input  wire rst_n,
  input  wire tick,
  input  wire io_pin,
  output reg  level_reg
);
  reg       m_reg;
  reg       s_reg;
  reg [8:0] cnt_reg;

  // pulsed lines with more high than low time still integrate up
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      m_reg     <= 1'b0;
      s_reg     <= 1'b0;
      cnt_reg   <= 9'h000;
      level_reg <= 1'b0;
    end else begin
      m_reg <= io_pin;
      s_reg <= m_reg;
      if (tick) begin
        if (s_reg && cnt_reg != FILT_MS)
          cnt_reg <= cnt_reg + 9'h001;
        else if (!s_reg && cnt_reg != 9'h000)
          cnt_reg <= cnt_reg - 9'h001;
      end
      if (cnt_reg == FILT_MS)
        level_reg <= 1'b1;
      else if (cnt_reg == 9'h000)
        level_reg <= 1'b0;
    end
  end
endmodule

// ===== sds_sequencer.v
/*
 * Smoke detector sequencer: sampling schedule, supervisory checks, alarm,
 * hush, interconnect, alarm memory and age count.
 * Assumes analog results arrive as asynchronous levels and are synchronised.
 */
`timescale 1ns/100ps
`include "sds_defines.vh"
module sds_sequencer #(
  parameter [31:0] TICK_CYC   = `SDS_TICK_NS / `SDS_CLK_PERIOD_NS,
  parameter [31:0] INFRARED_EMITTER_DRIVE_CYC   = (`SDS_INFRARED_EMITTER_DRIVE_STEP_US * 1000) / `SDS_CLK_PERIOD_NS,
  parameter [31:0] SAMPLE_MS  = `SDS_SAMPLE_S * 1000,
  parameter [31:0] SUPV_MS    = `SDS_SUPV_S * 1000,
  parameter [31:0] OFFSET_MS  = `SDS_OFFSET_S * 1000,
  parameter [31:0] HUSH_MS    = `SDS_HUSH_MIN * 60000,
  parameter [31:0] LBMUTE_MS  = `SDS_LBMUTE_H * 3600000,
  parameter [31:0] MEMSHOW_MS = `SDS_MEM_SHOW_H * 3600000,
  parameter [31:0] EOL_MS     = `SDS_EOL_DAYS * 86400000
) (
  input  wire       ref_clk,
  input  wire       rst_n,
  input  wire       button_in,
  input  wire       io_in,
  input  wire       compare_above_in,
  input  wire       battery_ok_in,
  input  wire [1:0] infrared_emitter_drive_time_sel,
  input  wire       lowbat_silence_en,
  input  wire       hush_cancel_en,
  input  wire       eol_enable,
  output reg        boost_enable,
  output reg        high_boost,
  output reg        reservoir_charge,
  output reg        detect_enable,
  output reg        infrared_emitter_drive,
  output reg  [1:0] gain_select,
  output reg  [1:0] limit_select,
  output reg        red_indicator_output,
  output reg        green_indicator_output,
  output reg        horn_metal_drive,
  output reg        horn_ceramic_drive,
  output reg        io_out,
  output reg        io_oe,
  output reg        io_discharge,
  output reg        button_check_mode,
  output reg        local_alarm,
  output reg        remote_alarm,
  output reg        hush_active,
  output reg        alarm_memory,
  output reg  [8:0] age_count,
  output reg        age_increment
);
  localparam [3:0] S_IDLE = 4'h1, S_WIN = 4'h2, S_INFRARED_EMITTER_DRIVE = 4'h4, S_TAIL = 4'h8;
  localparam [1:0] K_SMOKE = 2'h0, K_CHAMBER = 2'h1, K_BATTERY = 2'h2;
  localparam [8:0] EOL_AGE = (`SDS_EOL_YEARS * 365) / `SDS_EOL_DAYS;

  function [31:0] infrared_emitter_drive_cycles;
    input [1:0] sel;
    infrared_emitter_drive_cycles = ({30'h0, ~sel} + 32'h1) * INFRARED_EMITTER_DRIVE_CYC;
  endfunction

  reg btn_m, btn_s, btn_d, cmp_m, cmp_s, bat_m, bat_s;
  reg [31:0] tick_cnt, smp_cnt, supv_cnt, infrared_emitter_drive_cnt, hush_cnt, lbm_cnt, show_cnt, eol_cnt;
  reg        tick_reg, supv_odd, smp_pend, bat_pend, cham_pend;
  reg [8:0]  ph_cnt;
  reg [3:0]  state_reg;
  reg [1:0]  kind_reg, bat_idx, det_cnt, clr_cnt, cham_fail;
  reg [4:0]  win_ms;
  reg [11:0] dump_cnt, lbh_cnt;
  reg        lowbat, test_after, hush_pend, quit_press, lb_hold, mem_press;
  wire       io_filt;
  wire       horn_chirp;
  wire       green_flash;

  wire btn_rise = btn_s & ~btn_d;
  wire btn_fall = ~btn_s & btn_d;
  wire fast     = button_check_mode | test_after | local_alarm | det_cnt != 2'h0;
  wire ev_a     = tick_reg && supv_cnt == SUPV_MS - 32'h1;
  wire ev_b     = tick_reg && supv_cnt == OFFSET_MS - 32'h1;
  wire triple   = cham_fail == 2'h2 || (eol_enable && age_count >= EOL_AGE);
  wire idle_sup = ~local_alarm & ~remote_alarm;
  wire hs_start = idle_sup & ((ev_a & lowbat & lbm_cnt == 32'h0) |
                              (ev_b & (triple | cham_fail != 2'h0)));
  wire [1:0] hs_cnt = (ev_b & triple) ? 2'h3 : 2'h1;
  wire gr_start = ev_a & alarm_memory & show_cnt != 32'h0 & ~lowbat;
  wire end_pulse = state_reg == S_INFRARED_EMITTER_DRIVE && infrared_emitter_drive_cnt == infrared_emitter_drive_cycles(infrared_emitter_drive_time_sel) - 32'h1;
  wire infrared_emitter_drive_go   = state_reg == S_WIN && kind_reg != K_BATTERY && win_ms == `SDS_INFRARED_EMITTER_DRIVE_START_MS;
  wire smoke    = cmp_s;
  wire alarm_off = (end_pulse && kind_reg == K_SMOKE && local_alarm && !smoke &&
                    clr_cnt == 2'h2) || (btn_rise && local_alarm);

  sds_io_filter u_filt (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n & ~local_alarm),
    .tick      (tick_reg),
    .io_pin    (io_in),
    .level_reg (io_filt)
  );

  sds_burst u_horn (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .tick     (tick_reg),
    .start    (hs_start),
    .count    (hs_cnt),
    .on_ms    (12'd`SDS_CHIRP_MS),
    .gap_ms   (12'd`SDS_TRIPLE_GAP_MS),
    .busy_reg (),
    .out_reg  (horn_chirp)
  );

  sds_burst u_green (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .tick     (tick_reg),
    .start    (gr_start),
    .count    (2'h3),
    .on_ms    (12'd`SDS_FLASH_MS),
    .gap_ms   (12'd`SDS_MEM_GAP_MS),
    .busy_reg (),
    .out_reg  (green_flash)
  );

  // pin synchronisers, 1 ms tick and free-running phases
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      {btn_m, btn_s, btn_d, cmp_m, cmp_s, bat_m, bat_s} <= 7'h00;
      tick_cnt <= 32'h0;
      tick_reg <= 1'b0;
      ph_cnt   <= 9'h000;
      supv_cnt <= 32'h0;
      supv_odd <= 1'b0;
    end else begin
      btn_m <= button_in;
      btn_s <= btn_m;
      btn_d <= btn_s;
      cmp_m <= compare_above_in;
      cmp_s <= cmp_m;
      bat_m <= battery_ok_in;
      bat_s <= bat_m;
      tick_reg <= tick_cnt == TICK_CYC - 32'h1;
      tick_cnt <= (tick_cnt == TICK_CYC - 32'h1) ? 32'h0 : tick_cnt + 32'h1;
      if (tick_reg) begin
        ph_cnt <= (ph_cnt == `SDS_ALARM_RATE_MS - 1) ? 9'h000 : ph_cnt + 9'h001;
        supv_cnt <= (supv_cnt == SUPV_MS - 32'h1) ? 32'h0 : supv_cnt + 32'h1;
        if (supv_cnt == SUPV_MS - 32'h1)
          supv_odd <= ~supv_odd;
      end
    end
  end

  // measurement scheduler and window sequence
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      smp_cnt <= 32'h0;
      {smp_pend, bat_pend, cham_pend} <= 3'h0;
      state_reg <= S_IDLE;
      kind_reg  <= K_SMOKE;
      win_ms    <= 5'h00;
      infrared_emitter_drive_cnt  <= 32'h0;
    end else begin
      case (state_reg)
        S_IDLE: begin
          win_ms <= 5'h00;
          if (smp_pend || bat_pend || cham_pend) begin
            state_reg <= S_WIN;
            kind_reg  <= smp_pend ? K_SMOKE : (bat_pend ? K_BATTERY : K_CHAMBER);
            if (smp_pend)
              smp_pend <= 1'b0;
            else if (bat_pend)
              bat_pend <= 1'b0;
            else
              cham_pend <= 1'b0;
          end
        end
        S_WIN: begin
          if (tick_reg)
            win_ms <= win_ms + 5'h01;
          if (infrared_emitter_drive_go) begin
            state_reg <= S_INFRARED_EMITTER_DRIVE;
            infrared_emitter_drive_cnt  <= 32'h0;
          end else if (win_ms == `SDS_WINDOW_MS) begin
            state_reg <= S_IDLE;
          end
        end
        S_INFRARED_EMITTER_DRIVE: begin
          if (tick_reg)
            win_ms <= win_ms + 5'h01;
          infrared_emitter_drive_cnt <= infrared_emitter_drive_cnt + 32'h1;
          if (end_pulse)
            state_reg <= S_TAIL;
        end
        S_TAIL: begin
          if (tick_reg)
            win_ms <= win_ms + 5'h01;
          if (win_ms >= `SDS_WINDOW_MS)
            state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
      // new requests after the take, so a request never gets lost
      if (tick_reg) begin
        if (smp_cnt >= (fast ? `SDS_FAST_MS - 1 : SAMPLE_MS - 32'h1)) begin
          smp_cnt  <= 32'h0;
          smp_pend <= 1'b1;
        end else begin
          smp_cnt <= smp_cnt + 32'h1;
        end
      end
      if (ev_a && supv_odd)
        bat_pend <= 1'b1;
      if (ev_a && idle_sup && !button_check_mode && !test_after && !hush_active)
        cham_pend <= 1'b1;
    end
  end

  // detection, alarm, hush, supervision and button handling
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      {det_cnt, clr_cnt, cham_fail, bat_idx} <= 8'h00;
      {lowbat, test_after, hush_pend, quit_press, lb_hold, mem_press} <= 6'h00;
      {local_alarm, remote_alarm, hush_active, alarm_memory, button_check_mode} <= 5'h00;
      {hush_cnt, lbm_cnt, show_cnt, eol_cnt} <= 128'h0;
      dump_cnt <= 12'h000;
      lbh_cnt  <= 12'h000;
      age_count     <= 9'h000;
      age_increment <= 1'b0;
    end else begin
      age_increment <= 1'b0;
      remote_alarm  <= io_filt & ~local_alarm & ~alarm_off;
      if (end_pulse && kind_reg == K_SMOKE) begin
        if (local_alarm || test_after) begin
          clr_cnt <= smoke ? 2'h0 : clr_cnt + 2'h1;
          if (!smoke && clr_cnt == 2'h2) begin
            local_alarm <= 1'b0;
            test_after  <= 1'b0;
            clr_cnt     <= 2'h0;
            if (hush_pend) begin
              hush_active <= 1'b1;
              hush_cnt    <= HUSH_MS;
              hush_pend   <= 1'b0;
            end
          end
        end
        if (!local_alarm) begin
          det_cnt <= smoke ? det_cnt + 2'h1 : 2'h0;
          if (smoke && det_cnt == `SDS_DETECT_COUNT - 2'h1) begin
            local_alarm <= 1'b1;
            det_cnt     <= 2'h0;
            clr_cnt     <= 2'h0;
          end
        end
        if (smoke && hush_active && hush_cancel_en)
          hush_active <= 1'b0;
      end
      if (end_pulse && kind_reg == K_CHAMBER)
        cham_fail <= smoke ? 2'h0 : (cham_fail == 2'h2 ? 2'h2 : cham_fail + 2'h1);
      if (state_reg == S_WIN && kind_reg == K_BATTERY && win_ms == `SDS_WINDOW_MS) begin
        lowbat  <= ~bat_s;
        bat_idx <= bat_idx + 2'h1;
      end
      if (remote_alarm && hush_active && hush_cancel_en)
        hush_active <= 1'b0;
      if (btn_rise) begin
        mem_press <= alarm_memory;
        if (local_alarm) begin
          local_alarm <= 1'b0;
          quit_press  <= 1'b1;
        end else if (lowbat && lowbat_silence_en) begin
          lb_hold <= 1'b1;
          lbh_cnt <= 12'h000;
        end else begin
          button_check_mode <= 1'b1;
          if (hush_cancel_en)
            hush_active <= 1'b0;
        end
      end
      if (lb_hold && btn_s && tick_reg && !button_check_mode) begin
        lbh_cnt <= lbh_cnt + 12'h001;
        if (lbh_cnt == `SDS_LBHOLD_MS - 1)
          button_check_mode <= 1'b1;
      end
      if (btn_fall) begin
        if (mem_press)
          alarm_memory <= 1'b0;
        mem_press <= 1'b0;
        if (lb_hold)
          lbm_cnt <= LBMUTE_MS;
        lb_hold <= 1'b0;
        if (button_check_mode) begin
          button_check_mode <= 1'b0;
          test_after <= 1'b1;
          hush_pend  <= 1'b1;
        end else if (quit_press || lb_hold) begin
          hush_active <= 1'b1;
          hush_cnt    <= HUSH_MS;
        end
        quit_press <= 1'b0;
      end
      if (alarm_off) begin
        alarm_memory <= 1'b1;
        show_cnt     <= MEMSHOW_MS;
        dump_cnt     <= 12'd`SDS_IODUMP_MS;
      end
      if (tick_reg) begin
        if (dump_cnt != 12'h000 && !alarm_off)
          dump_cnt <= dump_cnt - 12'h001;
        if (show_cnt != 32'h0 && !alarm_off)
          show_cnt <= show_cnt - 32'h1;
        if (lbm_cnt != 32'h0 && !(btn_fall && lb_hold))
          lbm_cnt <= lbm_cnt - 32'h1;
        if (hush_cnt != 32'h0)
          hush_cnt <= hush_cnt - 32'h1;
        else if (!btn_fall)
          hush_active <= 1'b0;
        if (eol_enable) begin
          eol_cnt <= (eol_cnt == EOL_MS - 32'h1) ? 32'h0 : eol_cnt + 32'h1;
          if (eol_cnt == EOL_MS - 32'h1 && age_count != 9'h1FF) begin
            age_count     <= age_count + 9'h001;
            age_increment <= 1'b1;
          end
        end
      end
    end
  end

  // registered pin drives
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      {boost_enable, high_boost, reservoir_charge, detect_enable} <= 4'h0;
      {infrared_emitter_drive, red_indicator_output, green_indicator_output} <= 3'h0;
      {horn_metal_drive, horn_ceramic_drive, io_out, io_oe, io_discharge} <= 5'h00;
      gain_select  <= `SDS_GAIN_NORMAL;
      limit_select <= `SDS_LIM_NORMAL;
    end else begin
      boost_enable     <= state_reg != S_IDLE || local_alarm || remote_alarm;
      high_boost       <= (state_reg != S_IDLE && kind_reg == K_BATTERY && bat_idx == 2'h3) ||
                          local_alarm || remote_alarm;
      reservoir_charge <= state_reg == S_WIN && kind_reg != K_BATTERY &&
                          win_ms < `SDS_INFRARED_EMITTER_DRIVE_START_MS;
      detect_enable    <= state_reg != S_IDLE && kind_reg != K_BATTERY;
      infrared_emitter_drive <= infrared_emitter_drive_go || (state_reg == S_INFRARED_EMITTER_DRIVE && !end_pulse);
      if (button_check_mode || kind_reg == K_CHAMBER)
        gain_select <= `SDS_GAIN_HIGH;
      else if (hush_active)
        gain_select <= `SDS_GAIN_HUSH;
      else
        gain_select <= `SDS_GAIN_NORMAL;
      if (button_check_mode || kind_reg == K_CHAMBER)
        limit_select <= `SDS_LIM_CHAMBER;
      else if (local_alarm)
        limit_select <= `SDS_LIM_HYST;
      else if (hush_active)
        limit_select <= `SDS_LIM_HUSH;
      else
        limit_select <= `SDS_LIM_NORMAL;
      red_indicator_output <= (local_alarm && ph_cnt < `SDS_FLASH_MS) ||
        (hush_active && state_reg != S_IDLE && kind_reg == K_SMOKE) ||
        (state_reg != S_IDLE && kind_reg == K_BATTERY && bat_idx == 2'h3) ||
        (lb_hold && btn_s);
      green_indicator_output <= green_flash;
      horn_metal_drive <= local_alarm || remote_alarm || horn_chirp ||
        (alarm_memory && btn_s && !local_alarm &&
         (ph_cnt < `SDS_CHIRP_MS || (ph_cnt >= `SDS_FAST_MS && ph_cnt < `SDS_FAST_MS + `SDS_CHIRP_MS)));
      horn_ceramic_drive <= 1'b0;
      io_out       <= local_alarm;
      io_oe        <= local_alarm;
      io_discharge <= dump_cnt != 12'h000 && !local_alarm;
    end
  end
endmodule

// ===== sds_seq_props.sv
/* Port assertions for sds_sequencer.
   Assumes the bind hands on TICK_CYC and INFRARED_EMITTER_DRIVE_CYC. */
`timescale 1ns/100ps
module sds_seq_props #(
  parameter [31:0] TICK_CYC = 32'h0000000A,
  parameter [31:0] INFRARED_EMITTER_DRIVE_CYC = 32'h00000004
) (
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic [1:0] infrared_emitter_drive_time_sel,
  input wire logic       boost_enable,
  input wire logic       detect_enable,
  input wire logic       infrared_emitter_drive,
  input wire logic [1:0] limit_select,
  input wire logic       red_indicator_output,
  input wire logic       horn_metal_drive,
  input wire logic       io_out,
  input wire logic       io_oe,
  input wire logic       io_discharge,
  input wire logic       button_check_mode,
  input wire logic       local_alarm,
  input wire logic       remote_alarm
);
  logic [31:0] infrared_emitter_drive_cnt_reg, win_cnt_reg, dump_cnt_reg, red_cnt_reg, alm_cnt_reg;
  // run lengths of the high phases
  always @(posedge ref_clk) begin
    infrared_emitter_drive_cnt_reg <= (!rst_n || !infrared_emitter_drive) ? 32'h0 : infrared_emitter_drive_cnt_reg + 32'h1;
    win_cnt_reg  <= (!rst_n || !detect_enable) ? 32'h0 : win_cnt_reg + 32'h1;
    dump_cnt_reg <= (!rst_n || !io_discharge) ? 32'h0 : dump_cnt_reg + 32'h1;
    red_cnt_reg  <= (!rst_n || !red_indicator_output) ? 32'h0 : red_cnt_reg + 32'h1;
    alm_cnt_reg  <= (!rst_n || !local_alarm) ? 32'h0 : alm_cnt_reg + 32'h1;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_infrared_emitter_drive_window;
    infrared_emitter_drive |-> detect_enable && boost_enable;
  endproperty
  a_infrared_emitter_drive_window: assert property (p_infrared_emitter_drive_window) else $error("emitter outside window");
  property p_infrared_emitter_drive_width;
    $fell(infrared_emitter_drive) |-> infrared_emitter_drive_cnt_reg == INFRARED_EMITTER_DRIVE_CYC * (32'h4 - {30'h0, infrared_emitter_drive_time_sel});
  endproperty
  a_infrared_emitter_drive_width: assert property (p_infrared_emitter_drive_width) else $error("emitter width wrong");
  property p_window_len;
    $fell(detect_enable) |-> win_cnt_reg >= TICK_CYC * 32'h9 && win_cnt_reg <= TICK_CYC * 32'hB;
  endproperty
  a_window_len: assert property (p_window_len) else $error("window length wrong");
  property p_alarm_out;
    $rose(local_alarm) |-> ##[0:2] (io_oe && io_out && horn_metal_drive);
  endproperty
  a_alarm_out: assert property (p_alarm_out) else $error("alarm outputs missing");
  property p_io_ignored;
    $rose(remote_alarm) |-> !local_alarm;
  endproperty
  a_io_ignored: assert property (p_io_ignored) else $error("remote in local alarm");
  property p_dump_start;
    $fell(local_alarm) |-> ##[0:2] io_discharge;
  endproperty
  a_dump_start: assert property (p_dump_start) else $error("no discharge");
  property p_dump_len;
    $fell(io_discharge) |-> dump_cnt_reg >= TICK_CYC * 32'd1299 && dump_cnt_reg <= TICK_CYC * 32'd1301;
  endproperty
  a_dump_len: assert property (p_dump_len) else $error("discharge length wrong");
  property p_hyst;
    local_alarm && infrared_emitter_drive && !button_check_mode |-> limit_select == 2'h1;
  endproperty
  a_hyst: assert property (p_hyst) else $error("limit not hysteresis");
  property p_red_alarm;
    // skip a flash cut short by alarm entry
    $fell(red_indicator_output) && local_alarm && alm_cnt_reg > red_cnt_reg + 32'h2 |->
      red_cnt_reg >= TICK_CYC * 32'h9 && red_cnt_reg <= TICK_CYC * 32'hB;
  endproperty
  a_red_alarm: assert property (p_red_alarm) else $error("alarm flash length wrong");
  c_local: cover property ($rose(local_alarm));
  c_remote: cover property ($rose(remote_alarm));
  c_test: cover property ($rose(button_check_mode));
endmodule
bind sds_sequencer sds_seq_props #(.TICK_CYC(TICK_CYC), .INFRARED_EMITTER_DRIVE_CYC(INFRARED_EMITTER_DRIVE_CYC)) u_sds_seq_props (
  .ref_clk, .rst_n, .infrared_emitter_drive_time_sel, .boost_enable, .detect_enable, .infrared_emitter_drive,
  .limit_select, .red_indicator_output, .horn_metal_drive, .io_out, .io_oe, .io_discharge,
  .button_check_mode, .local_alarm, .remote_alarm);

// ===== sds_far_end.sv
/* Interconnect line with other detectors on it.
   Assumes a pull-down on the line; a remote high overrides the dump. */
`timescale 1ns/100ps
module sds_far_end (
  input  wire logic io_out,
  input  wire logic io_oe,
  input  wire logic io_discharge,
  input  wire logic remote_drive,
  output wire logic io_line
);
  assign io_line = remote_drive | (io_oe & io_out & ~io_discharge);
endmodule

// ===== tb_top.sv
/* Self-checking bench for sds_sequencer with scaled timing.
   Assumes 1 ms = TICK_CYC cycles and no supervisory check in the run. */
`timescale 1ns/100ps
module tb_top;
  localparam int T = 10;
  localparam int IC = 4;
  localparam int SMP = 40, SUP = 9000, OFS = 4000, HSH = 200, LBM = 300, MEM = 400, EOL = 100;
  logic       ref_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       button_in = 1'b0;
  logic       compare_above_in = 1'b0;
  logic       remote_drive = 1'b0;
  logic [1:0] infrared_emitter_drive_time_sel = 2'h3;
  logic       battery_ok_in = 1'b1;
  logic       lowbat_silence_en = 1'b0;
  logic       hush_cancel_en = 1'b0;
  logic       eol_enable = 1'b1;
  wire        io_line, boost_enable, high_boost, reservoir_charge, detect_enable, infrared_emitter_drive;
  wire        red_indicator_output, green_indicator_output, horn_metal_drive, horn_ceramic_drive;
  wire        io_out, io_oe, io_discharge, button_check_mode, local_alarm, remote_alarm;
  wire        hush_active, alarm_memory, age_increment;
  wire [1:0]  gain_select, limit_select;
  wire [8:0]  age_count;
  int         miscompares = 0;
  int         checked = 0;
  always #2.5 ref_clk = ~ref_clk;
  sds_sequencer #(.TICK_CYC(T), .INFRARED_EMITTER_DRIVE_CYC(IC), .SAMPLE_MS(SMP), .SUPV_MS(SUP), .OFFSET_MS(OFS),
    .HUSH_MS(HSH), .LBMUTE_MS(LBM), .MEMSHOW_MS(MEM), .EOL_MS(EOL)) u_sds_sequencer (
    .ref_clk, .rst_n, .button_in, .io_in(io_line), .compare_above_in, .battery_ok_in,
    .infrared_emitter_drive_time_sel, .lowbat_silence_en, .hush_cancel_en, .eol_enable,
    .boost_enable, .high_boost, .reservoir_charge, .detect_enable, .infrared_emitter_drive,
    .gain_select, .limit_select, .red_indicator_output, .green_indicator_output, .horn_metal_drive,
    .horn_ceramic_drive, .io_out, .io_oe, .io_discharge, .button_check_mode, .local_alarm,
    .remote_alarm, .hush_active, .alarm_memory, .age_count, .age_increment);
  sds_far_end u_sds_far_end (.io_out, .io_oe, .io_discharge, .remote_drive, .io_line);
  function automatic logic sig(input int k);
    case (k)
      0: return detect_enable;
      1: return infrared_emitter_drive;
      2: return local_alarm;
      3: return remote_alarm;
      4: return io_discharge;
      5: return button_check_mode;
      6: return horn_metal_drive;
      7: return hush_active;
      8: return age_increment;
      default: return red_indicator_output;
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask
  // n: falling edges waited until signal k shows v
  task automatic wt(input int k, input logic v, input int lim, output int n);
    n = 0;
    while (sig(k) !== v && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
    chk(n < lim, 1, "wait timed out");
  endtask
  task automatic test_done;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic t_age;
    int n;
    logic [8:0] a;
    wt(8, 1'b1, 1100, n);
    repeat (2) @(negedge ref_clk);
    a = age_count;
    wt(8, 1'b1, 1100, n);
    chk(n >= 100 * T - 10 && n <= 100 * T + 2, 1, "age period");
    repeat (2) @(negedge ref_clk);
    chk(age_count, a + 9'h1, "age step");
  endtask
  task automatic t_sample;
    int n;
    for (int s = 3; s >= 0; s--) begin
      infrared_emitter_drive_time_sel = s[1:0];
      wt(0, 1'b1, 500, n);
      chk({boost_enable, reservoir_charge, gain_select, limit_select}, 6'h30, "window");
      wt(1, 1'b1, 40, n);
      wt(1, 1'b0, 40, n);
      chk(n, IC * (4 - s), "emitter width");
      wt(0, 1'b0, 200, n);
    end
  endtask
  task automatic t_alarm;
    int n;
    compare_above_in = 1'b1;
    wt(2, 1'b1, 6000, n);
    repeat (2) @(negedge ref_clk);
    chk({io_oe, io_out, horn_metal_drive, high_boost, remote_alarm}, 5'h1E, "alarm outputs");
    remote_drive = 1'b1;
    wt(9, 1'b0, 200, n);
    wt(9, 1'b1, 5100, n);
    wt(9, 1'b0, 200, n);
    chk(n >= 9 * T && n <= 11 * T, 1, "alarm flash");
    wt(1, 1'b1, 3000, n);
    chk(limit_select, 2'h1, "hysteresis limit");
    repeat (4000) @(negedge ref_clk);
    chk(remote_alarm, 1'b0, "line ignored");
    remote_drive = 1'b0;
    compare_above_in = 1'b0;
    wt(2, 1'b0, 9000, n);
    repeat (2) @(negedge ref_clk);
    chk({alarm_memory, io_discharge, io_oe}, 3'h6, "alarm exit");
    wt(4, 1'b0, 14000, n);
    chk(n >= 1299 * T - 3 && n <= 1301 * T, 1, "discharge time");
  endtask
  task automatic t_remote;
    int n;
    remote_drive = 1'b1;
    repeat (2000) @(negedge ref_clk);
    remote_drive = 1'b0;
    repeat (4000) @(negedge ref_clk);
    chk(remote_alarm, 1'b0, "short pulse");
    remote_drive = 1'b1;
    wt(3, 1'b1, 4000, n);
    chk(n >= 334 * T && n <= 338 * T, 1, "filter delay");
    repeat (2) @(negedge ref_clk);
    chk({horn_metal_drive, red_indicator_output, local_alarm}, 3'h4, "remote outputs");
    remote_drive = 1'b0;
    wt(3, 1'b0, 5000, n);
  endtask
  task automatic t_button;
    int n;
    button_in = 1'b1;
    wt(5, 1'b1, 10, n);
    wt(1, 1'b1, 2600, n);
    chk(gain_select, 2'h2, "test gain");
    wt(6, 1'b0, 200, n);
    wt(6, 1'b1, 2600, n);
    wt(6, 1'b0, 200, n);
    chk(n >= 9 * T && n <= 11 * T, 1, "memory chirp");
    button_in = 1'b0;
    repeat (8) @(negedge ref_clk);
    chk(alarm_memory, 1'b0, "memory cleared");
    wt(1, 1'b1, 2600, n);
    chk(gain_select, 2'h0, "normal gain");
    wt(7, 1'b1, 9000, n);
    wt(1, 1'b1, 5000, n);
    chk(limit_select, 2'h2, "hush limit");
    hush_cancel_en = 1'b1;
    button_in = 1'b1;
    wt(7, 1'b0, 10, n);
  endtask
  initial begin
    repeat (2) @(negedge ref_clk);
    chk({boost_enable, high_boost, reservoir_charge, detect_enable, infrared_emitter_drive, gain_select,
      limit_select, red_indicator_output, green_indicator_output, horn_metal_drive, horn_ceramic_drive,
      io_out, io_oe, io_discharge, button_check_mode, local_alarm, remote_alarm, hush_active,
      alarm_memory, age_count, age_increment}, 0, "reset outputs");
    rst_n = 1'b1;
    t_age;
    t_sample;
    t_alarm;
    t_remote;
    t_button;
    test_done;
  end
  initial begin
    #500000;
    miscompares++;
    $display("[FAIL] %0t watchdog expired", $time);
    test_done;
  end
endmodule
